// File: pkg/agc_pkg.sv
`default_nettype none
package agc_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] CTRL_IDX = 8'h01;
    localparam logic [7:0] MONO_VOL_IDX = 8'h04;
    localparam logic [7:0] PAIR_ONE_VOL_IDX = 8'h05;
    localparam logic [7:0] PAIR_TWO_VOL_IDX = 8'h06;
    localparam logic [7:0] LIMIT_IDX = 8'h07;
    localparam logic [7:0] STEP_TIME_IDX = 8'h08;
    localparam logic [7:0] STATUS_IDX = 8'h09;

    // field positions
    localparam int SPK_EN_BIT = 1;
    localparam int HPR_EN_BIT = 2;
    localparam int HPL_EN_BIT = 3;
    localparam int AGC_EN_BIT = 5;
    localparam int SRC_SEL_LSB = 6;
    localparam int VOL_LSB = 0;
    localparam int TRIM_BYPASS_BIT = 6;
    localparam int SPK_BOOST_BIT = 7;
    localparam int TRIM_CODE_LSB = 5;
    localparam int SPK_LIMIT_LSB = 0;
    localparam int HP_LIMIT_LSB = 4;
    localparam int ATTACK_LSB = 0;
    localparam int RELEASE_LSB = 8;
    localparam int STAT_FIXED_LSB = 8;
    localparam int STAT_LIMIT_BIT = 16;
    localparam int STAT_STATE_LSB = 17;

    // reset values
    localparam logic [4:0] VOL_RST = 5'h0D;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // gain-step timing
    localparam int unsigned CLK_PERIOD_PS = 25_000;
    localparam int unsigned ATTACK_UNIT_NS = 1_280_000;
    localparam int unsigned RELEASE_UNIT_NS = 41_000_000;
    localparam int unsigned ATTACK_UNIT_CYC_DEF = ATTACK_UNIT_NS * 1000 / CLK_PERIOD_PS;
    localparam int unsigned RELEASE_UNIT_CYC_DEF = RELEASE_UNIT_NS / (CLK_PERIOD_PS / 1000);

    // volume code to gain in half-dB, two's complement
    localparam int GAIN_W = 9;
    localparam logic [GAIN_W-1:0] VOL_GAIN_HDB [32] = '{
        9'h17C, 9'h194, 9'h1AC, 9'h1B8, 9'h1C4, 9'h1D0, 9'h1DC, 9'h1E8,
        9'h1EE, 9'h1F4, 9'h1F7, 9'h1FA, 9'h1FD, 9'h000, 9'h002, 9'h004,
        9'h006, 9'h008, 9'h00A, 9'h00C, 9'h00E, 9'h010, 9'h012, 9'h014,
        9'h016, 9'h018, 9'h01A, 9'h01C, 9'h01E, 9'h020, 9'h022, 9'h024};
    localparam logic [4:0] UNITY_CODE = 5'h0D;
    localparam logic [4:0] FIRST_FINE_CODE = 5'h0E;
    localparam logic [GAIN_W-1:0] FIRST_FINE_HDB = 9'h002;

    // limiter thresholds in millivolts peak
    localparam logic [15:0] SPK_LIMIT_MV [8] = '{
        16'h0A28, 16'h0BB8, 16'h0CE4, 16'h0E10, 16'h0F3C, 16'h1068, 16'h12C0, 16'h1450};
    localparam logic [15:0] HP_LIMIT_MV [8] = '{
        16'h028A, 16'h02EE, 16'h033E, 16'h0384, 16'h03CA, 16'h041A, 16'h04B0, 16'h0514};
    // headphone trim as linear factor, Q8; index 8 is the bypass (0 dB)
    localparam logic [8:0] TRIM_SCALE_Q8 [9] = '{
        9'h040, 9'h04C, 9'h05B, 9'h06C, 9'h080, 9'h098, 9'h0B5, 9'h0D7, 9'h100};

    // control register layout
    typedef struct packed {
        logic [1:0] src_sel;
        logic agc_en;
        logic spare;
        logic hpl_en;
        logic hpr_en;
        logic spk_en;
        logic spare0;
    } ctrl_s;

    typedef enum logic [2:0] {
        ST_HOLD = 3'b001,
        ST_ATTACK = 3'b010,
        ST_RELEASE = 3'b100
    } agc_state_e;

endpackage
`default_nettype wire

// File: hw/vol_gain_rom.sv
`timescale 1ns/1ps
`default_nettype none
module vol_gain_rom
    import agc_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // lookup
    input wire logic [4:0] code,
    output logic [GAIN_W-1:0] gain_hdb_q
);

    // registered read of the audio-taper table
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gain_hdb_q <= '0;
        else
            gain_hdb_q <= VOL_GAIN_HDB[code];
    end

endmodule // vol_gain_rom
`default_nettype wire

// File: hw/audio_volume_and_limiter_agc.sv
// Contract
// - five-bit volume code, -66 to +18 dB
// - coarse low steps, 1 dB steps above unity
// - gain control only limits, never boosts
// - lower gain while signal above limit
// - raise gain below limit, toward volume gain
// - speaker limit wins when both enabled
// - headphone only: louder channel drives gain
// - speaker limit code picks eight thresholds
// - speaker thresholds hold for 6 dB setting
// - headphone threshold scales with headphone trim
// - attack step is (code+1) times 1.28 ms
// - release step is (code+1) times 41 ms
// - volume codes in registers four, five, six
// - trim: bypass bit plus three-bit code
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module audio_volume_and_limiter_agc
    import agc_pkg::*;
#(
    parameter int unsigned ATTACK_UNIT_CYC = ATTACK_UNIT_CYC_DEF,
    parameter int unsigned RELEASE_UNIT_CYC = RELEASE_UNIT_CYC_DEF,
    parameter int LEVEL_W = 16
)(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // measured output peaks in millivolts
    input wire logic [LEVEL_W-1:0] spk_level_mv,
    input wire logic [LEVEL_W-1:0] hpl_level_mv,
    input wire logic [LEVEL_W-1:0] hpr_level_mv,
    // applied gain
    output logic [GAIN_W-1:0] applied_gain_hdb,
    output logic [4:0] applied_step,
    output logic limiting
);

    ctrl_s ctrl_q;
    logic [7:0] mono_q;
    logic [7:0] pair_one_q;
    logic [7:0] pair_two_q;
    logic [7:0] limit_q;
    logic [12:0] step_time_q;
    logic [31:0] prdata_q;
    logic err_q;
    logic [4:0] gain_q;
    logic [4:0] gain_d;
    logic [31:0] timer_q;
    logic [31:0] timer_d;
    logic limiting_q;
    logic [4:0] fixed_code;
    agc_state_e state_q;
    agc_state_e state_d;

    // apb address decode
    wire [5:0] reg_idx = paddr[7:2];
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire hit_ctrl = reg_idx == CTRL_IDX[5:0];
    wire hit_mono = reg_idx == MONO_VOL_IDX[5:0];
    wire hit_one = reg_idx == PAIR_ONE_VOL_IDX[5:0];
    wire hit_two = reg_idx == PAIR_TWO_VOL_IDX[5:0];
    wire hit_limit = reg_idx == LIMIT_IDX[5:0];
    wire hit_time = reg_idx == STEP_TIME_IDX[5:0];
    wire hit_stat = reg_idx == STATUS_IDX[5:0];
    wire mapped = hit_ctrl || hit_mono || hit_one || hit_two || hit_limit || hit_time || hit_stat;
    wire wr_en = access && pwrite && mapped;

    // configuration fields
    wire [4:0] mono_vol = mono_q[VOL_LSB +: 5];
    wire [4:0] stereo_pair_one_vol = pair_one_q[VOL_LSB +: 5];
    wire [4:0] stereo_pair_two_vol = pair_two_q[VOL_LSB +: 5];
    wire headphone_trim_bypass = pair_one_q[TRIM_BYPASS_BIT];
    wire [2:0] headphone_trim_code = pair_two_q[TRIM_CODE_LSB +: 3];
    wire [2:0] speaker_limit_code = limit_q[SPK_LIMIT_LSB +: 3];
    wire [2:0] headphone_limit_code = limit_q[HP_LIMIT_LSB +: 3];
    wire [4:0] attack_step_code = step_time_q[ATTACK_LSB +: 5];
    wire [4:0] release_step_code = step_time_q[RELEASE_LSB +: 5];

    // read mux
    wire [2:0] state_bits = state_q;
    wire [31:0] stat_word = {12'h000, state_bits, limiting_q, 3'h0, fixed_code, 3'h0, gain_q};
    wire [31:0] rd_data =
        hit_ctrl ? {24'h00_0000, ctrl_q} :
        hit_mono ? {24'h00_0000, mono_q} :
        hit_one ? {24'h00_0000, pair_one_q} :
        hit_two ? {24'h00_0000, pair_two_q} :
        hit_limit ? {24'h00_0000, limit_q} :
        hit_time ? {19'h0_0000, step_time_q} :
        hit_stat ? stat_word : RDATA_ZERO;

    // zero-wait answer; read data and error captured in the setup cycle
    assign pready = access;
    assign prdata = prdata_q;
    assign pslverr = access && err_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= RDATA_ZERO;
            err_q <= 1'b0;
        end
        else if (setup)
        begin
            prdata_q <= pwrite ? RDATA_ZERO : rd_data;
            err_q <= !mapped;
        end
    end

    // software registers; status is read-only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= CTRL_RST;
            mono_q <= {3'h0, VOL_RST};
            pair_one_q <= {3'h0, VOL_RST};
            pair_two_q <= {3'h0, VOL_RST};
            limit_q <= 8'h00;
            step_time_q <= 13'h0000;
        end
        else if (wr_en)
        begin
            if (hit_ctrl)
                ctrl_q <= pwdata[7:0];
            if (hit_mono)
                mono_q <= {3'h0, pwdata[4:0]};
            if (hit_one)
                pair_one_q <= {pwdata[7:6], 1'b0, pwdata[4:0]};
            if (hit_two)
                pair_two_q <= pwdata[7:0];
            if (hit_limit)
                limit_q <= pwdata[7:0] & 8'h77;
            if (hit_time)
                step_time_q <= pwdata[12:0] & 13'h1F1F;
        end
    end

    // fixed volume gain of the selected input path
    assign fixed_code =
        (ctrl_q.src_sel == 2'd1) ? stereo_pair_one_vol :
        (ctrl_q.src_sel == 2'd2) ? stereo_pair_two_vol : mono_vol;

    // limiter thresholds; output-referred, so the 6 dB speaker setting
    // thresholds are also used under boost
    wire [15:0] spk_thr = SPK_LIMIT_MV[speaker_limit_code];
    wire [3:0] trim_idx = headphone_trim_bypass ? 4'd8 : {1'b0, headphone_trim_code};
    wire [24:0] hp_prod = HP_LIMIT_MV[headphone_limit_code] * TRIM_SCALE_Q8[trim_idx];
    wire [15:0] hp_thr = hp_prod[23:8];

    // level detect and source choice
    wire [LEVEL_W-1:0] hpl_seen = ctrl_q.hpl_en ? hpl_level_mv : '0;
    wire [LEVEL_W-1:0] hpr_seen = ctrl_q.hpr_en ? hpr_level_mv : '0;
    wire [LEVEL_W-1:0] hp_peak = (hpl_seen > hpr_seen) ? hpl_seen : hpr_seen;
    wire hp_on = ctrl_q.hpl_en || ctrl_q.hpr_en;
    wire over =
        ctrl_q.spk_en ? (spk_level_mv > LEVEL_W'(spk_thr)) :
        hp_on ? (hp_peak > LEVEL_W'(hp_thr)) : 1'b0;

    // interval length for the current direction
    wire [31:0] attack_len = 32'((32'(attack_step_code) + 32'd1) * ATTACK_UNIT_CYC);
    wire [31:0] release_len = 32'((32'(release_step_code) + 32'd1) * RELEASE_UNIT_CYC);
    wire [31:0] step_len = (state_q == ST_ATTACK) ? attack_len : release_len;
    wire above_fixed = gain_q > fixed_code;
    wire at_floor = gain_q == 5'h00;
    wire step_due = (state_q != ST_HOLD) && (timer_q == step_len - 32'd1);

    // direction decision
    always_comb
    begin
        state_d = ST_HOLD;
        if (!ctrl_q.agc_en || above_fixed)
            state_d = ST_HOLD;
        else if (over && gain_q != 5'h00)
            state_d = ST_ATTACK;
        else if (!over && gain_q < fixed_code)
            state_d = ST_RELEASE;
    end

    // gain stepping
    always_comb
    begin
        gain_d = gain_q;
        timer_d = (state_d == state_q && !step_due) ? timer_q + 32'd1 : 32'h0000_0000;
        if (!ctrl_q.agc_en || above_fixed)
            gain_d = fixed_code;
        else if (step_due)
        begin
            unique case (state_q)
                // hold at the bottom code so the step never wraps
                ST_ATTACK: gain_d = at_floor ? gain_q : gain_q - 5'd1;
                ST_RELEASE: gain_d = gain_q + 5'd1;
                ST_HOLD: gain_d = gain_q;
            endcase
        end
        if (state_d == ST_HOLD)
            timer_d = 32'h0000_0000;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_HOLD;
            gain_q <= VOL_RST;
            timer_q <= 32'h0000_0000;
            limiting_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            gain_q <= gain_d;
            timer_q <= timer_d;
            limiting_q <= over;
        end
    end

    // applied gain lookup
    vol_gain_rom u_rom (
        .pclk(pclk),
        .presetn(presetn),
        .code(gain_q),
        .gain_hdb_q(applied_gain_hdb)
    );

    assign applied_step = gain_q;
    assign limiting = limiting_q;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_gain_ceiling: assert property ((ctrl_q.agc_en && above_fixed) |=> gain_q == $past(fixed_code))
        else $error("gain above volume gain not pulled down");
    a_agc_off_fixed: assert property (!ctrl_q.agc_en |=> gain_q == $past(fixed_code))
        else $error("agc off but gain not at volume code");
    a_attack_step: assert property ((ctrl_q.agc_en && !above_fixed && !at_floor && step_due
        && state_q == ST_ATTACK) |=> gain_q == $past(gain_q) - 5'd1)
        else $error("attack interval did not drop one step");
    a_release_step: assert property ((ctrl_q.agc_en && !above_fixed && step_due && state_q == ST_RELEASE)
        |=> gain_q == $past(gain_q) + 5'd1 && gain_q <= $past(fixed_code))
        else $error("release interval did not raise one step");
    a_hold_between: assert property ((ctrl_q.agc_en && !above_fixed && !step_due)
        |=> gain_q == $past(gain_q))
        else $error("gain moved before its interval elapsed");
    a_spk_first: assert property ((ctrl_q.spk_en && hp_on && spk_level_mv <= LEVEL_W'(spk_thr))
        |=> !limiting_q)
        else $error("headphone level limited while speaker enabled");
    a_hp_louder: assert property ((!ctrl_q.spk_en && ctrl_q.hpl_en && ctrl_q.hpr_en
        && hpr_level_mv > LEVEL_W'(hp_thr)) |=> limiting_q)
        else $error("louder headphone channel ignored");
    a_unity_code: assert property ((gain_q == UNITY_CODE) |=> applied_gain_hdb == 9'h000)
        else $error("unity code not 0 dB");
    a_fine_code: assert property ((gain_q == FIRST_FINE_CODE) |=> applied_gain_hdb == FIRST_FINE_HDB)
        else $error("first fine code not +1 dB");
    a_step_timer: assert property ((state_q == ST_ATTACK && step_due)
        |-> timer_q >= 32'(ATTACK_UNIT_CYC) - 32'd1)
        else $error("attack interval shorter than one unit");
    a_floor_hold: assert property ((ctrl_q.agc_en && at_floor && state_q != ST_RELEASE) |=> at_floor)
        else $error("gain left the bottom code while not releasing");
    a_timer_restart: assert property ((state_d != state_q) |=> timer_q == 32'd0)
        else $error("interval timer not restarted on direction change");

    // bus and status
    a_apb_ready: assert property ((psel && penable) |-> pready && (pslverr == !mapped))
        else $error("access phase without ready or with wrong error");
    a_read_zero_write: assert property ((setup && pwrite) |=> prdata_q == RDATA_ZERO)
        else $error("write cycle left read data set");
    a_status_gain: assert property ((setup && !pwrite && hit_stat) |=> prdata_q[4:0] == $past(gain_q))
        else $error("status read lost the gain step");

    // limiter thresholds and source choice
    a_trim_bypass: assert property (headphone_trim_bypass |-> hp_thr == HP_LIMIT_MV[headphone_limit_code])
        else $error("bypassed trim changed the headphone limit");
    a_trim_half: assert property ((!headphone_trim_bypass && headphone_trim_code == 3'd4)
        |-> hp_thr == (HP_LIMIT_MV[headphone_limit_code] >> 1))
        else $error("half trim did not halve the headphone limit");
    a_trim_quarter: assert property ((!headphone_trim_bypass && headphone_trim_code == 3'd0)
        |-> hp_thr == (HP_LIMIT_MV[headphone_limit_code] >> 2))
        else $error("lowest trim did not quarter the headphone limit");
    a_limit_follow: assert property ((ctrl_q.spk_en && spk_level_mv > LEVEL_W'(spk_thr)) |=> limiting_q)
        else $error("speaker level over limit not flagged");
    a_hp_off_quiet: assert property ((!ctrl_q.spk_en && !hp_on) |=> !limiting_q)
        else $error("limiting with no amplifier enabled");

    c_attack: cover property (state_q == ST_ATTACK && step_due);
    c_release: cover property (state_q == ST_RELEASE && step_due);
    c_hp_only: cover property (!ctrl_q.spk_en && hp_on && over);
    c_apb_write: cover property (wr_en && hit_limit);
    c_gain_ceiling: cover property (ctrl_q.agc_en && above_fixed);

endmodule // audio_volume_and_limiter_agc
`default_nettype wire

// File: dv/apb_host.sv
`timescale 1ns/1ps
`default_nettype none
// host side: apb master that programs the block
module apb_host (
    // clock
    input wire logic pclk,
    // apb master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready
);
    // idle bus at time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    // setup, access held until pready, then release
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // released data does not keep its value
    endtask
endmodule // apb_host
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import agc_pkg::*;
    // bench state
    logic pclk, presetn, snap, psel, penable, pwrite, pready, pslverr, limiting;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, lfsr_q;
    logic [15:0] spk_mv, hpl_mv, hpr_mv;
    logic [8:0] gain;
    logic [4:0] step;
    logic [32:0] expq[$];
    int fail_count, num_checks;
    int vol_hdb[13] = '{-132, -108, -84, -72, -60, -48, -36, -24, -18, -12, -9, -6, -3};
    int spk_thr[8] = '{2600, 3000, 3300, 3600, 3900, 4200, 4800, 5200};
    int atk[3] = '{0, 7, 31};
    int rel[3] = '{0, 31, 2};
    logic [7:0] regs[6] = '{CTRL_IDX, MONO_VOL_IDX, PAIR_ONE_VOL_IDX, PAIR_TWO_VOL_IDX, LIMIT_IDX, STEP_TIME_IDX};
    logic [31:0] masks[6] = '{32'h0000_00FF, 32'h0000_001F, 32'h0000_00DF, 32'h0000_00FF, 32'h0000_0077,
        32'h0000_1F1F};
    // ctrl, limit, pair one, pair two, spk, hpl, hpr, limiting
    int hp_case[11][8] = '{'{10, 112, 77, 13, 100, 1400, 0, 0}, '{10, 112, 77, 13, 2601, 0, 0, 1},
        '{12, 112, 77, 13, 0, 0, 1301, 1}, '{12, 112, 77, 13, 0, 1300, 1200, 0}, '{8, 112, 77, 13, 0, 1301, 0, 1},
        '{8, 112, 77, 13, 0, 0, 5000, 0}, '{12, 112, 13, 141, 0, 651, 0, 1}, '{12, 112, 13, 141, 0, 650, 0, 0},
        '{12, 112, 13, 13, 0, 0, 326, 1}, '{12, 112, 13, 13, 0, 0, 325, 0}, '{12, 112, 13, 13, 0, 0, 0, 0}};

    audio_volume_and_limiter_agc #(.ATTACK_UNIT_CYC(4), .RELEASE_UNIT_CYC(8), .LEVEL_W(16))
        u_audio_volume_and_limiter_agc (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .spk_level_mv(spk_mv), .hpl_level_mv(hpl_mv), .hpr_level_mv(hpr_mv), .applied_gain_hdb(gain),
        .applied_step(step), .limiting(limiting));
    apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready));

    // 40 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [8:0] exp_gain(input int c);
        return (c < 13) ? 9'(vol_hdb[c]) : 9'(2 * (c - 13));
    endfunction
    task automatic check(input string nm, input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        host.xfer(1'b1, 8'(idx << 2), d);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [32:0] e);
        expq.push_back(e);
        host.xfer(1'b0, 8'(idx << 2), 32'h0000_0000);
    endtask
    // note limiting and gain, then ask the watcher to compare
    task automatic look(input logic [9:0] e);
        repeat (3) @(posedge pclk);
        expq.push_back({23'h00_0000, e});
        snap <= 1'b1;
        @(posedge pclk);
        snap <= 1'b0;
    endtask
    // cycles from step a showing until step b shows
    task automatic span(input logic [4:0] a, input logic [4:0] b, input int n, input string nm);
        int c;
        c = 0;
        for (int i = 0; i < 3000 && step !== a; i++)
            @(posedge pclk);
        while (step !== b && c < 3000)
        begin
            @(posedge pclk);
            c++;
        end
        check(nm, 33'(c), 33'(n));
    endtask

    // watcher: oldest note against each read or snapshot
    always @(posedge pclk)
    begin : watch
        logic [32:0] e;
        if ((psel && penable && pready && !pwrite) || snap)
        begin
            e = (expq.size() > 0) ? expq.pop_front() : 33'h1_FFFF_FFFF;
            if (snap)
                check("limiting and gain", {23'h00_0000, limiting, gain}, e);
            else
                check("read data", {pslverr, prdata}, e);
        end
    end

    // main sequence
    initial
    begin
        presetn = 1'b0;
        snap = 1'b0;
        spk_mv = 16'h0000;
        hpl_mv = 16'h0000;
        hpr_mv = 16'h0000;
        fail_count = 0;
        num_checks = 0;
        lfsr_q = 32'h0000_9742;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(CTRL_IDX, 33'h0_0000_0000);
        rd(MONO_VOL_IDX, 33'h0_0000_000D);
        rd(PAIR_ONE_VOL_IDX, 33'h0_0000_000D);
        rd(PAIR_TWO_VOL_IDX, 33'h0_0000_000D);
        rd(8'h00, 33'h1_0000_0000);
        rd(8'h0F, 33'h1_0000_0000);
        for (int i = 0; i < 6; i++)
        begin
            lfsr_q = lfsr_next(lfsr_q);
            wr(regs[i], lfsr_q);
            rd(regs[i], {1'b0, lfsr_q & masks[i]});
        end
        // volume table with the limiter idle
        wr(CTRL_IDX, 32'h0000_0000);
        wr(LIMIT_IDX, 32'h0000_0000);
        for (int c = 0; c < 32; c++)
        begin
            wr(MONO_VOL_IDX, 32'(c));
            look({1'b0, exp_gain(c)});
        end
        wr(PAIR_ONE_VOL_IDX, 32'h0000_001F);
        wr(CTRL_IDX, 32'h0000_0040);
        look({1'b0, exp_gain(31)});
        wr(PAIR_TWO_VOL_IDX, 32'h0000_0000);
        wr(CTRL_IDX, 32'h0000_0080);
        look({1'b0, exp_gain(0)});
        // speaker thresholds
        wr(CTRL_IDX, 32'h0000_0002);
        wr(MONO_VOL_IDX, 32'h0000_000D);
        for (int i = 0; i < 8; i++)
        begin
            wr(LIMIT_IDX, 32'(i));
            spk_mv <= 16'(spk_thr[i]);
            look(10'h000);
            spk_mv <= 16'(spk_thr[i] + 1);
            look(10'h200);
        end
        // headphone limits, trims and priority
        for (int i = 0; i < 11; i++)
        begin
            wr(CTRL_IDX, 32'(hp_case[i][0]));
            wr(LIMIT_IDX, 32'(hp_case[i][1]));
            wr(PAIR_ONE_VOL_IDX, 32'(hp_case[i][2]));
            wr(PAIR_TWO_VOL_IDX, 32'(hp_case[i][3]));
            spk_mv <= 16'(hp_case[i][4]);
            hpl_mv <= 16'(hp_case[i][5]);
            hpr_mv <= 16'(hp_case[i][6]);
            look({1'(hp_case[i][7]), 9'h000});
        end
        // limiter attack and release step timing
        wr(LIMIT_IDX, 32'h0000_0000);
        for (int i = 0; i < 3; i++)
        begin
            wr(STEP_TIME_IDX, 32'((rel[i] << 8) | atk[i]));
            wr(CTRL_IDX, 32'h0000_0022);
            spk_mv <= 16'h0A29;
            span(5'h0C, 5'h0B, (atk[i] + 1) * 4, "attack interval");
            spk_mv <= 16'h0000;
            span(5'h0C, 5'h0D, (rel[i] + 1) * 8, "release interval");
            repeat (300) @(posedge pclk);
            rd(STATUS_IDX, 33'h0_0002_0D0D);
        end
        // lowering the volume under a running limiter pulls gain down at once
        spk_mv <= 16'h0A29;
        wr(MONO_VOL_IDX, 32'h0000_0000);
        look({1'b1, exp_gain(0)});
        give_verdict;
    end

    // watchdog against a hang
    initial
    begin
        repeat (60000) @(posedge pclk);
        fail_count++;
        give_verdict;
    end
endmodule // tb
`default_nettype wire
